// ===== bsa_array.sv
// cascaded four-bit slice array with pipeline register, end shift muxes and status bits
`timescale 1ns/1ps
`include "bsa_map.svh"

module bsa_array #(
	parameter int SLICES = 3
) (
	// clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// microprogram store side
	input  wire bsa_pkg::bsa_uword_t           uword_i,
	input  wire logic [SLICES*4-1:0]           data_i,
	// wishbone slave
	input  wire logic                          cyc_i,
	input  wire logic                          stb_i,
	input  wire logic                          we_i,
	input  wire logic [3:0]                    adr_i,
	input  wire logic [3:0]                    sel_i,
	input  wire logic [31:0]                   dat_i,
	output logic      [31:0]                   dat_o,
	output logic                               ack_o,
	// results
	output bsa_pkg::bsa_status_t               status_o,
	output logic      [SLICES*4-1:0]           file_word_o,
	output logic      [SLICES*4-1:0]           aux_word_o
);

	localparam int W = SLICES * `BSA_SLICE_BITS;

	typedef struct packed {
		bsa_pkg::bsa_uword_t  pipe;
		logic [W-1:0]         pipe_data;
		logic [W-1:0]         file_word;
		logic [W-1:0]         aux_word;
		bsa_pkg::bsa_status_t status;
		logic [1:0]           ctrl;
		logic                 ack;
		logic [31:0]          rdata;
	} bsa_state_t;

	bsa_state_t state_reg;
	bsa_state_t state_next;

	// slice nets
	logic [W-1:0]      alu_f;
	logic [SLICES:0]   carry;
	logic [SLICES-1:0] slice_zero;
	logic [SLICES-1:0] slice_ovr;
	logic [SLICES-1:0] slice_g;
	logic [SLICES-1:0] slice_p;
	logic [W-1:0]      file_sh;
	logic [W-1:0]      aux_sh;
	// end shift lines, each with its enable as a three-state pin would have
	logic              file_bottom_shift_line;
	logic              aux_reg_bottom_shift_line;
	logic              file_top_shift_line;
	logic              aux_reg_top_shift_line;
	logic              up_mux_oe;
	logic              down_mux_oe;
	logic              lookahead_carry;

	wire logic          shift_up = state_reg.pipe.shift_direction_bit;
	wire logic [W-1:0]  b_oper   = (state_reg.pipe.op == bsa_pkg::BSA_OP_SUB) ?
		~state_reg.pipe_data : state_reg.pipe_data;

	function automatic logic fill_bit(input bsa_pkg::bsa_fill_t mode, input logic wrap,
		input logic arith);
		unique case (mode)
			bsa_pkg::BSA_FILL_ZERO:   fill_bit = 1'b0;
			bsa_pkg::BSA_FILL_ONE:    fill_bit = 1'b1;
			bsa_pkg::BSA_FILL_ROTATE: fill_bit = wrap;
			bsa_pkg::BSA_FILL_ARITH:  fill_bit = arith;
		endcase
	endfunction : fill_bit

	assign carry[0] = state_reg.pipe.slice_carry_in;

	genvar s;
	generate
		for (s = 0; s < SLICES; s++) begin : g_slice
			localparam int LO = s * `BSA_SLICE_BITS;
			logic [3:0] a;
			logic [3:0] b;
			logic [4:0] sum;
			logic [3:0] low3;
			logic       up_in_f;
			logic       up_in_q;
			logic       dn_in_f;
			logic       dn_in_q;
			assign a    = state_reg.file_word[LO +: 4];
			assign b    = b_oper[LO +: 4];
			assign sum  = {1'b0, a} + {1'b0, b} + {4'h0, carry[s]};
			assign low3 = {1'b0, a[2:0]} + {1'b0, b[2:0]} + {3'h0, carry[s]};
			always_comb begin
				unique case (state_reg.pipe.op)
					bsa_pkg::BSA_OP_PASS: alu_f[LO +: 4] = state_reg.pipe_data[LO +: 4];
					bsa_pkg::BSA_OP_AND:  alu_f[LO +: 4] = a & state_reg.pipe_data[LO +: 4];
					default:              alu_f[LO +: 4] = sum[3:0];
				endcase
			end
			// logic ops leave no carry, so the chain reads zero past them
			assign carry[s+1] = (state_reg.pipe.op == bsa_pkg::BSA_OP_ADD ||
				state_reg.pipe.op == bsa_pkg::BSA_OP_SUB) ? sum[4] : 1'b0;
			assign slice_ovr[s]  = carry[s+1] ^ low3[3];
			assign slice_zero[s] = ~|alu_f[LO +: 4];
			assign slice_g[s]    = carry[s+1] & ~(&(a ^ b));
			assign slice_p[s]    = &(a ^ b);
			// neighbour lines: top of one slice meets bottom of the next
			if (s == 0) begin : g_bot
				assign up_in_f = file_bottom_shift_line;
				assign up_in_q = aux_reg_bottom_shift_line;
			end else begin : g_mid_lo
				assign up_in_f = alu_f[LO-1];
				assign up_in_q = state_reg.aux_word[LO-1];
			end
			if (s == SLICES - 1) begin : g_top
				assign dn_in_f = file_top_shift_line;
				assign dn_in_q = aux_reg_top_shift_line;
			end else begin : g_mid_hi
				assign dn_in_f = alu_f[LO+4];
				assign dn_in_q = state_reg.aux_word[LO+4];
			end
			assign file_sh[LO +: 4] = shift_up ? {alu_f[LO +: 3], up_in_f} :
				{dn_in_f, alu_f[LO+1 +: 3]};
			assign aux_sh[LO +: 4]  = shift_up ? {state_reg.aux_word[LO +: 3], up_in_q} :
				{dn_in_q, state_reg.aux_word[LO+1 +: 3]};
		end
	endgenerate

	// group carry from slice generate and propagate terms
	always_comb begin
		logic c;
		c = carry[0];
		for (int i = 0; i < SLICES; i++) begin
			c = slice_g[i] | (slice_p[i] & c);
		end
		lookahead_carry = c;
	end

	// end multiplexers: only the one chosen by direction drives its lines
	always_comb begin
		up_mux_oe   = shift_up;
		down_mux_oe = ~shift_up;
		file_bottom_shift_line    = 1'b0;
		aux_reg_bottom_shift_line = 1'b0;
		file_top_shift_line       = 1'b0;
		aux_reg_top_shift_line    = 1'b0;
		if (up_mux_oe) begin
			file_bottom_shift_line    = fill_bit(state_reg.pipe.shift_mode_sel, alu_f[W-1],
				state_reg.aux_word[W-1]);
			aux_reg_bottom_shift_line = fill_bit(state_reg.pipe.shift_mode_sel,
				state_reg.aux_word[W-1], 1'b0);
		end
		if (down_mux_oe) begin
			file_top_shift_line    = fill_bit(state_reg.pipe.shift_mode_sel, alu_f[0],
				alu_f[W-1]);
			aux_reg_top_shift_line = fill_bit(state_reg.pipe.shift_mode_sel,
				state_reg.aux_word[0], alu_f[0]);
		end
	end

	wire logic bus_req = cyc_i & stb_i & ~state_reg.ack;
	wire logic run     = state_reg.ctrl[`BSA_CTRL_RUN];

	always_comb begin
		state_next     = state_reg;
		// stopped array loads a no-op so nothing changes while software inspects it
		state_next.pipe      = run ? uword_i : '0;
		state_next.pipe_data = data_i;
		if (state_reg.pipe.write_file) begin
			state_next.file_word = state_reg.pipe.shift_file ? file_sh : alu_f;
		end
		if (state_reg.pipe.load_aux) begin
			state_next.aux_word = alu_f;
		end else if (state_reg.pipe.shift_aux) begin
			state_next.aux_word = aux_sh;
		end
		if (state_reg.pipe.write_file || state_reg.pipe.load_aux) begin
			state_next.status.zero     = &slice_zero;
			state_next.status.overflow = slice_ovr[SLICES-1];
			state_next.status.negative = alu_f[W-1];
			state_next.status.carry    = state_reg.ctrl[`BSA_CTRL_LOOKAHD] ?
				lookahead_carry : carry[SLICES];
		end
		state_next.ack   = bus_req;
		state_next.rdata = 32'h0;
		if (bus_req) begin
			if (we_i && sel_i[0] && adr_i == `BSA_OFF_CTRL) begin
				state_next.ctrl = dat_i[1:0];
			end
			unique case (adr_i)
				`BSA_OFF_CTRL:   state_next.rdata = {30'h0, state_reg.ctrl};
				`BSA_OFF_STATUS: state_next.rdata = {28'h0, state_reg.status};
				`BSA_OFF_FILE:   state_next.rdata = 32'(state_reg.file_word);
				`BSA_OFF_AUX:    state_next.rdata = 32'(state_reg.aux_word);
				default:         state_next.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg      <= '0;
			state_reg.ctrl <= `BSA_CTRL_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign dat_o       = state_reg.rdata;
	assign ack_o       = state_reg.ack;
	assign status_o    = state_reg.status;
	assign file_word_o = state_reg.file_word;
	assign aux_word_o  = state_reg.aux_word;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_PIPE_DELAY: assert property (run |=> state_reg.pipe == $past(uword_i))
		else $error("microword not held in pipeline one cycle");
	AST_ZERO_FLAG: assert property ((state_reg.pipe.write_file || state_reg.pipe.load_aux)
		|=> status_o.zero == ($past(alu_f) == '0))
		else $error("zero status disagrees with result");
	AST_NEG_FLAG: assert property (state_reg.pipe.write_file
		|=> status_o.negative == $past(alu_f[W-1]))
		else $error("negative status not result sign");
	AST_OVR_FLAG: assert property ((state_reg.pipe.op == bsa_pkg::BSA_OP_ADD &&
		state_reg.pipe.write_file && !state_reg.pipe.shift_file)
		|=> status_o.overflow == (($past(state_reg.file_word[W-1]) ==
		$past(state_reg.pipe_data[W-1])) && (file_word_o[W-1] !=
		$past(state_reg.file_word[W-1]))))
		else $error("overflow status wrong for add");
	AST_CARRY_FLAG: assert property (state_reg.pipe.write_file &&
		!state_reg.ctrl[`BSA_CTRL_LOOKAHD] |=> status_o.carry == $past(carry[SLICES]))
		else $error("carry status not top slice carry");
	AST_LA_EQUAL: assert property (lookahead_carry == carry[SLICES])
		else $error("look-ahead carry differs from ripple");
	AST_ONE_DRIVER: assert property (!(up_mux_oe && down_mux_oe))
		else $error("both end multiplexers drive");
	AST_ROT_UP: assert property (state_reg.pipe.write_file && state_reg.pipe.shift_file &&
		shift_up && state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ROTATE
		|=> file_word_o == {$past(alu_f[W-2:0]), $past(alu_f[W-1])})
		else $error("up rotate lost a bit");
	AST_ARITH_DN: assert property (state_reg.pipe.write_file && state_reg.pipe.shift_file &&
		state_reg.pipe.shift_aux && !state_reg.pipe.load_aux && !shift_up &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ARITH
		|=> file_word_o[W-1] == file_word_o[W-2] && aux_word_o[W-1] == $past(alu_f[0]))
		else $error("arithmetic down shift wrong");
	AST_ARITH_UP: assert property (state_reg.pipe.shift_aux && !state_reg.pipe.load_aux &&
		shift_up && state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ARITH
		|=> aux_word_o[0] == 1'b0)
		else $error("arithmetic up shift did not clear aux bottom");
	AST_ZERO_FILL: assert property (state_reg.pipe.write_file && state_reg.pipe.shift_file &&
		!shift_up && state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ZERO
		|=> file_word_o[W-1] == 1'b0)
		else $error("zero fill not low");
	AST_ONE_FILL: assert property (state_reg.pipe.write_file && state_reg.pipe.shift_file &&
		shift_up && state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ONE
		|=> file_word_o[0] == 1'b1)
		else $error("one fill not high");
	AST_WB_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus ack not a single cycle");

	// whole-word sums: a broken carry link between slices shows here, not per slice
	AST_ADD_SUM: assert property (
		state_reg.pipe.op == bsa_pkg::BSA_OP_ADD
		|-> {carry[SLICES], alu_f} == ({1'b0, state_reg.file_word} +
		{1'b0, state_reg.pipe_data} + (W+1)'(state_reg.pipe.slice_carry_in)))
		else $error("ripple add result wrong");
	AST_SUB_SUM: assert property (
		state_reg.pipe.op == bsa_pkg::BSA_OP_SUB
		|-> {carry[SLICES], alu_f} == ({1'b0, state_reg.file_word} +
		{1'b0, ~state_reg.pipe_data} + (W+1)'(state_reg.pipe.slice_carry_in)))
		else $error("ripple subtract result wrong");
	// the AND op must not leave a carry at the top of the ripple chain
	AST_AND_NO_CARRY: assert property (
		state_reg.pipe.op == bsa_pkg::BSA_OP_AND |-> carry[SLICES] == 1'b0)
		else $error("logic op produced a carry");

	// end fills the older checks leave open: other direction and the aux word
	AST_ZERO_FILL_UP: assert property (
		state_reg.pipe.write_file && state_reg.pipe.shift_file && shift_up &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ZERO
		|=> file_word_o[0] == 1'b0)
		else $error("zero fill up not low");
	AST_ZERO_AUX_DN: assert property (
		state_reg.pipe.shift_aux && !state_reg.pipe.load_aux && !shift_up &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ZERO
		|=> aux_word_o[W-1] == 1'b0)
		else $error("zero fill down not low in aux");
	AST_ONE_FILL_DN: assert property (
		state_reg.pipe.shift_aux && !state_reg.pipe.load_aux && !shift_up &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ONE
		|=> aux_word_o[W-1] == 1'b1)
		else $error("one fill down not high in aux");
	AST_ROT_DN: assert property (
		state_reg.pipe.write_file && state_reg.pipe.shift_file && !shift_up &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ROTATE
		|=> file_word_o == {$past(alu_f[0]), $past(alu_f[W-1:1])})
		else $error("down rotate lost a bit");
	AST_ROT_AUX: assert property (
		state_reg.pipe.shift_aux && !state_reg.pipe.load_aux && shift_up &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ROTATE
		|=> aux_word_o == {$past(state_reg.aux_word[W-2:0]), $past(state_reg.aux_word[W-1])})
		else $error("aux up rotate lost a bit");
	AST_ROT_AUX_DN: assert property (
		state_reg.pipe.shift_aux && !state_reg.pipe.load_aux && !shift_up &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ROTATE
		|=> aux_word_o == {$past(state_reg.aux_word[0]), $past(state_reg.aux_word[W-1:1])})
		else $error("aux down rotate lost a bit");
	AST_ARITH_UP_FILE: assert property (
		state_reg.pipe.write_file && state_reg.pipe.shift_file && shift_up &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ARITH
		|=> file_word_o[0] == $past(state_reg.aux_word[W-1]))
		else $error("arithmetic up shift did not move aux top into file");

	// slice links: every inner bit must come from its neighbour, whatever the fill
	AST_FILE_LINK: assert property (
		state_reg.pipe.write_file && state_reg.pipe.shift_file && shift_up
		|=> file_word_o[W-1:1] == $past(alu_f[W-2:0]))
		else $error("result did not shift up as one word");
	AST_AUX_LINK: assert property (
		state_reg.pipe.shift_aux && !state_reg.pipe.load_aux && !shift_up
		|=> aux_word_o[W-2:0] == $past(state_reg.aux_word[W-1:1]))
		else $error("aux did not shift down as one word");
	AST_LOAD_AUX: assert property (
		state_reg.pipe.load_aux |=> aux_word_o == $past(alu_f))
		else $error("aux load did not take the result");

	// quiet cycles must leave the file word and status alone, and a stopped array takes no microword
	AST_HOLD_FILE: assert property (
		!state_reg.pipe.write_file |=> $stable(file_word_o))
		else $error("file word changed without a write");
	AST_HOLD_STATUS: assert property (
		!(state_reg.pipe.write_file || state_reg.pipe.load_aux) |=> $stable(status_o))
		else $error("status changed without a write");
	AST_STOP_NOOP: assert property (
		!run |=> state_reg.pipe == '0)
		else $error("stopped array took a microword");

	COV_ROTATE: cover property (state_reg.pipe.shift_file &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ROTATE);
	COV_ARITH_DOUBLE: cover property (state_reg.pipe.shift_file && state_reg.pipe.shift_aux &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ARITH);
	COV_OVERFLOW: cover property (status_o.overflow);
	COV_LOOKAHEAD: cover property (state_reg.ctrl[`BSA_CTRL_LOOKAHD] && status_o.carry);
	COV_DOWN_ONE: cover property (state_reg.pipe.shift_aux && !shift_up &&
		state_reg.pipe.shift_mode_sel == bsa_pkg::BSA_FILL_ONE);

endmodule : bsa_array

// ===== bsa_map.svh
// register offsets, field positions, reset values and end-fill codes of the slice array
`ifndef BSA_MAP_SVH
`define BSA_MAP_SVH

`define BSA_OFF_CTRL      4'h0
`define BSA_OFF_STATUS    4'h4
`define BSA_OFF_FILE      4'h8
`define BSA_OFF_AUX       4'hc
`define BSA_ADDR_LSB      2
`define BSA_ADDR_MSB      3

`define BSA_CTRL_RUN      0
`define BSA_CTRL_LOOKAHD  1
`define BSA_CTRL_RESET    2'h0

`define BSA_ST_ZERO       0
`define BSA_ST_OVERFLOW   1
`define BSA_ST_NEGATIVE   2
`define BSA_ST_CARRY      3

`define BSA_SLICE_BITS    4
`define BSA_SLICE_TOP     3

`define BSA_FILL_ZERO     2'h0
`define BSA_FILL_ONE      2'h1
`define BSA_FILL_ROTATE   2'h2
`define BSA_FILL_ARITH    2'h3

`endif

// ===== bsa_pkg.sv
// types shared by the slice array: microword fields and status flags
package bsa_pkg;

	typedef enum logic [1:0] {
		BSA_OP_PASS,
		BSA_OP_ADD,
		BSA_OP_SUB,
		BSA_OP_AND
	} bsa_op_t;

	typedef enum logic [1:0] {
		BSA_FILL_ZERO,
		BSA_FILL_ONE,
		BSA_FILL_ROTATE,
		BSA_FILL_ARITH
	} bsa_fill_t;

	// control field of one microword, data word travels beside it
	typedef struct packed {
		logic      shift_direction_bit;
		bsa_fill_t shift_mode_sel;
		bsa_op_t   op;
		logic      slice_carry_in;
		logic      write_file;
		logic      shift_file;
		logic      load_aux;
		logic      shift_aux;
	} bsa_uword_t;

	typedef struct packed {
		logic carry;
		logic negative;
		logic overflow;
		logic zero;
	} bsa_status_t;

endpackage : bsa_pkg

// ===== bsa_useq_model.sv
// microprogram store and sequencer model that feeds the array pipeline register
`timescale 1ns/1ps

module bsa_useq_model #(
	parameter int W = 12 // data width, a whole number of slices
) (
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// microword and data toward the array
	output bsa_pkg::bsa_uword_t  uword_o,
	output logic [W-1:0]         data_o
);
	bsa_pkg::bsa_uword_t uq[$];
	logic [W-1:0]        dq[$];

	task push(input bsa_pkg::bsa_uword_t w, input logic [W-1:0] d);
		uq.push_back(w);
		dq.push_back(d);
	endtask : push

	// one word per edge from a register on the array clock, fetch overlaps execution
	always @(posedge clk_i) begin
		if (rst_i) begin
			uword_o <= '0;
			data_o  <= '0;
		end else if (uq.size() != 0) begin
			uword_o <= uq.pop_front();
			data_o  <= dq.pop_front();
		end else begin
			// idle store sends a no-op; data toggles so no stale value looks valid
			uword_o <= '0;
			data_o  <= ~data_o;
		end
	end
endmodule : bsa_useq_model

// ===== test_bsa_array.sv
// self-checking bench for the slice array: bus, pipeline, status and end shifts
`timescale 1ns/1ps

module test_bsa_array;
	localparam int SLICES = 3;
	localparam int W      = SLICES * 4;

	logic                 clk_i;
	logic                 rst_i;
	bsa_pkg::bsa_uword_t  uword_i;
	logic [W-1:0]         data_i;
	logic                 cyc_i;
	logic                 stb_i;
	logic                 we_i;
	logic [3:0]           adr_i;
	logic [3:0]           sel_i;
	logic [31:0]          dat_i;
	logic [31:0]          dat_o;
	logic                 ack_o;
	bsa_pkg::bsa_status_t status_o;
	logic [W-1:0]         file_word_o;
	logic [W-1:0]         aux_word_o;
	int                   num_errors;
	int                   samples_checked;
	logic [W-1:0]         fexp;
	logic [3:0]           sexp;

	bsa_array #(.SLICES(SLICES)) bsa_array_inst (.clk_i(clk_i), .rst_i(rst_i),
		.uword_i(uword_i), .data_i(data_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.status_o(status_o), .file_word_o(file_word_o), .aux_word_o(aux_word_o));
	bsa_useq_model #(.W(W)) bsa_useq_model_inst (.clk_i(clk_i), .rst_i(rst_i),
		.uword_o(uword_i), .data_o(data_i));

	always #12.5 clk_i = ~clk_i;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task results();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	task wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [31:0] q);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i  <= we;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 16);
		q = dat_o;
		if (ack_o !== 1'h1) begin
			num_errors++;
			results();
		end
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		#1;
	endtask : wb

	task rd(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'h0, a, 32'h0, 4'hf, q);
		check(q, exp);
	endtask : rd

	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		wb(1'h1, a, d, s, q);
	endtask : wr

	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	// ctl is {write_file, shift_file, load_aux, shift_aux}
	function automatic bsa_pkg::bsa_uword_t uw(input logic dir, input logic [1:0] mode,
			input logic [1:0] op, input logic cin, input logic [3:0] ctl);
		return bsa_pkg::bsa_uword_t'({dir, mode, op, cin, ctl});
	endfunction : uw

	// returns {carry, negative, overflow, zero, result}
	function automatic logic [W+3:0] alu(input logic [1:0] op, input logic [W-1:0] a,
			input logic [W-1:0] d, input logic c);
		logic [W-1:0] b;
		logic [W:0]   s;
		logic [W-1:0] lo;
		b  = (op == 2'h2) ? ~d : d;
		s  = {1'h0, a} + {1'h0, b} + {{W{1'h0}}, c};
		lo = {1'h0, a[W-2:0]} + {1'h0, b[W-2:0]} + {{(W-1){1'h0}}, c};
		if (op == 2'h0)
			s = {1'h0, d};
		if (op == 2'h3)
			s = {1'h0, a & d};
		return {s[W], s[W-1], s[W] ^ lo[W-1], s[W-1:0] == '0, s[W-1:0]};
	endfunction : alu

	task reset_run();
		for (int i = 0; i < 4; i++)
			rd(4'(i * 4), 32'h0);
		rd(4'h2, 32'h0);
		wr(4'h0, 32'h3, 4'he);
		rd(4'h0, 32'h0);
		wr(4'h8, 32'h5a5, 4'hf);
		rd(4'h8, 32'h0);
		bsa_useq_model_inst.push(uw(1'h0, 2'h0, 2'h1, 1'h1, 4'h8), 12'h123);
		tick(4);
		check(file_word_o, 32'h0);
	endtask : reset_run

	task status_run(input logic [31:0] ctrl);
		logic [1:0]   ops [6] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h0, 2'h2};
		logic [W-1:0] dat [6] = '{12'h800, 12'h800, 12'h7ff, 12'h900, 12'h100, 12'h001};
		logic         cin [6] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
		logic [W+3:0] r;
		logic [3:0]   m;
		wr(4'h0, ctrl, 4'h1);
		rd(4'h0, ctrl);
		for (int i = 0; i < 6; i++) begin
			r = alu(ops[i], fexp, dat[i], cin[i]);
			// overflow only carries meaning for add and subtract
			m = (ops[i] == 2'h1 || ops[i] == 2'h2) ? 4'hf : 4'hd;
			bsa_useq_model_inst.push(uw(1'h0, 2'h0, ops[i], cin[i], 4'h8), dat[i]);
			tick(2);
			check(file_word_o, fexp);
			tick(1);
			check(file_word_o, r[W-1:0]);
			check(status_o & m, r[W+3:W] & m);
			fexp = r[W-1:0];
			sexp = r[W+3:W];
		end
		rd(4'h4, {28'h0, sexp});
	endtask : status_run

	task shift_run();
		logic [W-1:0] a;
		logic [W-1:0] b;
		logic [W-1:0] fe;
		logic [W-1:0] qe;
		logic         ff;
		logic         fq;
		a = 12'hc34;
		b = 12'ha52;
		for (int k = 0; k < 8; k++) begin
			ff = k[0];
			fq = k[0];
			if (k[1:0] == 2'h2) begin
				ff = k[2] ? b[W-1] : b[0];
				fq = k[2] ? a[W-1] : a[0];
			end
			if (k[1:0] == 2'h3) begin
				ff = k[2] ? a[W-1] : b[W-1];
				fq = k[2] ? 1'h0 : b[0];
			end
			fe = k[2] ? {b[W-2:0], ff} : {ff, b[W-1:1]};
			qe = k[2] ? {a[W-2:0], fq} : {fq, a[W-1:1]};
			bsa_useq_model_inst.push(uw(1'h0, 2'h0, 2'h0, 1'h0, 4'ha), a);
			bsa_useq_model_inst.push(uw(k[2], k[1:0], 2'h0, 1'h0, 4'hd), b);
			tick(4);
			check(file_word_o, fe);
			check(aux_word_o, qe);
		end
		rd(4'h8, {20'h0, fe});
		rd(4'hc, {20'h0, qe});
	endtask : shift_run

	initial begin
		clk_i           = 1'h0;
		rst_i           = 1'h1;
		cyc_i           = 1'h0;
		stb_i           = 1'h0;
		we_i            = 1'h0;
		adr_i           = 4'h0;
		sel_i           = 4'h0;
		dat_i           = 32'h0;
		num_errors      = 0;
		samples_checked = 0;
		fexp            = '0;
		sexp            = 4'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		#1;
		reset_run();
		status_run(32'h1);
		status_run(32'h3);
		shift_run();
		results();
	end
endmodule : test_bsa_array
